// ===== hw/sif_params.svh
`ifndef SIF_PARAMS_SVH
`define SIF_PARAMS_SVH
// register byte offsets
`define SIF_OFS_BUILD_LO 16'h0002
`define SIF_OFS_BUILD_HI 16'h0003
`define SIF_OFS_MAP_CNT 16'h0004
`define SIF_OFS_SYNC_CNT 16'h0005
`define SIF_OFS_RAM_SIZE 16'h0006
`define SIF_OFS_PORT_DESC 16'h0007
`define SIF_OFS_FEAT_LO 16'h0008
`define SIF_OFS_FEAT_HI 16'h0009
`define SIF_OFS_STADDR_LO 16'h0010
`define SIF_OFS_STADDR_HI 16'h0011
// feature word bit positions
`define SIF_FEAT_BYTE_MAP 0
`define SIF_FEAT_TIME_SYNC 2
`define SIF_FEAT_TIME_64 3
`define SIF_FEAT_LOW_JITTER 4
`define SIF_FEAT_LINK_LVDS 5
`define SIF_FEAT_LINK_MII 6
`define SIF_FEAT_FCS_SEP 7
`define SIF_FEAT_SYNC_ACT 8
// reset values
`define SIF_STADDR_RST 16'h0000
`define SIF_RDATA_RST 8'h00
`endif

// ===== hw/sif_pkg.sv
package sif_pkg;
  // port physical type codes
  typedef enum logic [1:0] {
    SIF_PORT_ABSENT = 2'b00,
    SIF_PORT_UNCONF = 2'b01,
    SIF_PORT_LVDS = 2'b10,
    SIF_PORT_MII = 2'b11
  } sif_port_type_t;
endpackage : sif_pkg

// ===== hw/sif_rd_mux.sv
`timescale 1ns/10ps
`include "sif_params.svh"
// byte read decoder, instantiated once for each access side
module sif_rd_mux (
  input wire logic [15:0] i_addr, // byte address
  input wire logic [15:0] i_build, // build number
  input wire logic [7:0] i_map_cnt, // mapping unit count
  input wire logic [7:0] i_sync_cnt, // sync channel count
  input wire logic [7:0] i_ram_kb, // ram size
  input wire logic [7:0] i_port_desc, // port descriptor
  input wire logic [15:0] i_feat, // feature word
  input wire logic [15:0] i_staddr, // station address
  output logic [7:0] o_data // selected byte
);
  // ----------------------------------------
  // byte select
  // ----------------------------------------
  // unmapped addresses read zero
  always_comb begin
    unique case (i_addr)
      `SIF_OFS_BUILD_LO: o_data = i_build[7:0];
      `SIF_OFS_BUILD_HI: o_data = i_build[15:8];
      `SIF_OFS_MAP_CNT: o_data = i_map_cnt;
      `SIF_OFS_SYNC_CNT: o_data = i_sync_cnt;
      `SIF_OFS_RAM_SIZE: o_data = i_ram_kb;
      `SIF_OFS_PORT_DESC: o_data = i_port_desc;
      `SIF_OFS_FEAT_LO: o_data = i_feat[7:0];
      `SIF_OFS_FEAT_HI: o_data = i_feat[15:8];
      `SIF_OFS_STADDR_LO: o_data = i_staddr[7:0];
      `SIF_OFS_STADDR_HI: o_data = i_staddr[15:8];
      default: o_data = 8'h00;
    endcase
  end
endmodule : sif_rd_mux

// ===== hw/sif_regs.sv
`timescale 1ns/10ps
`include "sif_params.svh"
// ----------------------------------------
// identity and feature register bank
// ----------------------------------------
module sif_regs #(
  parameter logic [3:0] BUILD_MAJOR_NIB = 4'h0, // upper build byte nibble, arbitrary
  parameter logic [3:0] BUILD_UPPER = 4'h0, // build bits 11:8, arbitrary
  parameter logic [3:0] BUILD_MINOR = 4'h2, // minor version
  parameter logic [3:0] BUILD_MAINT = 4'h0, // maintenance version
  parameter logic [7:0] MAP_UNITS = 8'h08, // memory map unit count
  parameter logic [7:0] SYNC_CHANNELS = 8'h08, // buffer sync channel count
  parameter logic [7:0] RAM_KBYTES = 8'h04, // process ram size in kbyte
  parameter logic [1:0] PORT0_TYPE = 2'b11, // port 0 code
  parameter logic [1:0] PORT1_TYPE = 2'b11, // port 1 code
  parameter logic [1:0] PORT2_TYPE = 2'b00, // port 2 code
  parameter logic [1:0] PORT3_TYPE = 2'b00, // port 3 code
  parameter bit BYTE_MAPPING = 1'b0, // byte oriented mapping
  parameter bit HAS_TIME_SYNC = 1'b1, // time sync unit present
  parameter bit TIME_SYNC_64 = 1'b0, // 64-bit time counter
  parameter bit LOW_JITTER_LVDS = 1'b0, // low jitter forwarding
  parameter bit LINK_DET_LVDS = 1'b0, // lvds enhanced link detect
  parameter bit LINK_DET_MII = 1'b0, // mii enhanced link detect
  parameter bit FCS_SEPARATE = 1'b1, // separate fcs error count
  parameter bit SYNC_ACTIVATION = 1'b0 // enhanced sync activation
) (
  input wire logic i_sys_clk, // system clock
  input wire logic i_sys_rst, // async reset, active high
  input wire logic i_net_rd, // network side read strobe
  input wire logic i_net_wr, // network side write strobe
  input wire logic [15:0] i_net_addr, // network side byte address
  input wire logic [7:0] i_net_wdata, // network side write byte
  output logic [7:0] o_net_rdata, // network side read byte
  input wire logic i_host_rd, // host side read strobe
  input wire logic i_host_wr, // host side write strobe
  input wire logic [15:0] i_host_addr, // host side byte address
  input wire logic [7:0] i_host_wdata, // host side write byte, ignored
  output logic [7:0] o_host_rdata, // host side read byte
  output logic [15:0] o_station_addr // station address for address match
);
  // ----------------------------------------
  // constant capability values
  // ----------------------------------------
  // capability bytes are fixed when the core is built and ignore every write;
  // only the station address and the two read holding registers carry state
  // usage notes:
  // - every access is one byte; a 16-bit register is two bytes, low byte at
  //   the even address, and each byte is written on its own
  // - read data is registered and stands from the cycle after the strobe
  // - unmapped addresses read as zero and ignore writes, with no error flag
  // - a write and a read of the same byte in one cycle return the old byte
  // - the station address resets to zero, so the node answers no configured
  //   address commands until the master has written it
  localparam int PORTS = 4; // ports covered by the port descriptor
  localparam logic [1:0] PORT_CODES [PORTS] = '{
    PORT0_TYPE, PORT1_TYPE, PORT2_TYPE, PORT3_TYPE}; // port 0 first

  logic [15:0] build_w;
  wire logic [7:0] port_desc_w;
  logic [15:0] feat_w;
  logic [15:0] staddr_r;
  logic [15:0] staddr_nxt;
  logic staddr_lo_wr;
  logic staddr_hi_wr;
  logic [7:0] net_rdata_r;
  logic [7:0] net_rdata_nxt;
  logic [7:0] host_rdata_r;
  logic [7:0] host_rdata_nxt;
  logic [7:0] net_byte;
  logic [7:0] host_byte;

  // build number fields; the low byte carries minor and maintenance versions
  assign build_w = {BUILD_MAJOR_NIB, BUILD_UPPER, BUILD_MINOR, BUILD_MAINT};

  // port descriptor, one bit pair per port, port 0 lowest; the enum cast
  // keeps each code inside the four defined port types
  for (genvar g = 0; g < PORTS; g++) begin : g_port_desc
    sif_pkg::sif_port_type_t code_w;
    assign code_w = sif_pkg::sif_port_type_t'(PORT_CODES[g]);
    assign port_desc_w[2*g+1:2*g] = code_w;
  end

  // feature word assembly; reserved bits 1 and 15:9 stay zero
  // each option bit copies its build parameter; options left out read zero
  always_comb begin
    feat_w = 16'h0000;
    feat_w[`SIF_FEAT_BYTE_MAP] = BYTE_MAPPING;
    feat_w[`SIF_FEAT_TIME_SYNC] = HAS_TIME_SYNC;
    feat_w[`SIF_FEAT_TIME_64] = TIME_SYNC_64;
    feat_w[`SIF_FEAT_LOW_JITTER] = LOW_JITTER_LVDS;
    feat_w[`SIF_FEAT_LINK_LVDS] = LINK_DET_LVDS;
    feat_w[`SIF_FEAT_LINK_MII] = LINK_DET_MII;
    feat_w[`SIF_FEAT_FCS_SEP] = FCS_SEPARATE;
    feat_w[`SIF_FEAT_SYNC_ACT] = SYNC_ACTIVATION;
  end

  // ----------------------------------------
  // read decoders
  // ----------------------------------------
  // one decoder per side, so a host read never waits on a network read and
  // both sides may read the same byte in the same cycle
  // unmapped addresses fall through to zero inside the decoder
  sif_rd_mux u_net_mux (
    .i_addr(i_net_addr),
    .i_build(build_w),
    .i_map_cnt(MAP_UNITS),
    .i_sync_cnt(SYNC_CHANNELS),
    .i_ram_kb(RAM_KBYTES),
    .i_port_desc(port_desc_w),
    .i_feat(feat_w),
    .i_staddr(staddr_r),
    .o_data(net_byte)
  );

  sif_rd_mux u_host_mux (
    .i_addr(i_host_addr),
    .i_build(build_w),
    .i_map_cnt(MAP_UNITS),
    .i_sync_cnt(SYNC_CHANNELS),
    .i_ram_kb(RAM_KBYTES),
    .i_port_desc(port_desc_w),
    .i_feat(feat_w),
    .i_staddr(staddr_r),
    .o_data(host_byte)
  );

  // ----------------------------------------
  // station address
  // ----------------------------------------
  // byte lane write enables; only the network side reaches this register
  // host writes never reach it, so the local side cannot move the node address
  assign staddr_lo_wr = i_net_wr && (i_net_addr == `SIF_OFS_STADDR_LO);
  assign staddr_hi_wr = i_net_wr && (i_net_addr == `SIF_OFS_STADDR_HI);

  // next value: each lane is written on its own, the other keeps its byte
  always_comb begin
    staddr_nxt = staddr_r;
    if (staddr_lo_wr) begin
      staddr_nxt[7:0] = i_net_wdata;
    end
    if (staddr_hi_wr) begin
      staddr_nxt[15:8] = i_net_wdata;
    end
  end

  // station address register, cleared to zero by reset
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      staddr_r <= `SIF_STADDR_RST;
    end else begin
      staddr_r <= staddr_nxt;
    end
  end

  // ----------------------------------------
  // network side read data
  // ----------------------------------------
  // a read loads the addressed byte, which then stands until the next read;
  // a write in the same cycle is seen by the following read only
  always_comb begin
    net_rdata_nxt = net_rdata_r;
    if (i_net_rd) begin
      net_rdata_nxt = net_byte;
    end
  end

  // network read holding register
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      net_rdata_r <= `SIF_RDATA_RST;
    end else begin
      net_rdata_r <= net_rdata_nxt;
    end
  end

  // ----------------------------------------
  // host side read data
  // ----------------------------------------
  // host reads mirror the network side; host writes are taken on the bus
  // but reach no register, so the local side can never change anything
  // the host write byte and strobe are therefore left unread on purpose
  always_comb begin
    host_rdata_nxt = host_rdata_r;
    if (i_host_rd) begin
      host_rdata_nxt = host_byte;
    end
  end

  // host read holding register
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      host_rdata_r <= `SIF_RDATA_RST;
    end else begin
      host_rdata_r <= host_rdata_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // every output comes straight from a register
  // so the far side never sees decode glitches
  assign o_net_rdata = net_rdata_r;
  assign o_host_rdata = host_rdata_r;
  assign o_station_addr = staddr_r;
endmodule : sif_regs

// ===== testbench/sif_regs_properties.sv
`timescale 1ns/10ps
// watches both read sides and the station address of the register bank
module sif_regs_checker (
  input wire logic i_sys_clk, // clock
  input wire logic i_sys_rst, // reset
  input wire logic i_net_rd, // net read
  input wire logic i_net_wr, // net write
  input wire logic [15:0] i_net_addr, // net address
  input wire logic [7:0] i_net_wdata, // net write byte
  input wire logic i_host_rd, // host read
  input wire logic [15:0] i_host_addr, // host address
  input wire logic [7:0] o_net_rdata, // net read byte
  input wire logic [7:0] o_host_rdata, // host read byte
  input wire logic [15:0] o_station_addr // station address
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);
  // station address writes, readback and protection
  a_stad_lo: assert property (i_net_wr && i_net_addr == 16'h0010
    |=> o_station_addr[7:0] == $past(i_net_wdata)) else $error("low byte not taken");
  a_stad_hi: assert property (i_net_wr && i_net_addr == 16'h0011
    |=> o_station_addr[15:8] == $past(i_net_wdata)) else $error("high byte not taken");
  a_stad_keep: assert property (!i_net_wr |=> $stable(o_station_addr))
    else $error("station address moved without net write");
  a_other_wr: assert property (i_net_wr && i_net_addr[15:1] != 15'h0008
    |=> $stable(o_station_addr)) else $error("stray write changed address");
  a_stad_rd: assert property (i_net_rd && i_net_addr == 16'h0011
    |=> o_net_rdata == $past(o_station_addr[15:8])) else $error("bad address readback");
  // reserved feature bits and agreement of the two sides
  a_feat_hi: assert property (i_net_rd && i_net_addr == 16'h0009
    |=> o_net_rdata[7:1] == 7'h00) else $error("reserved high feature bits set");
  a_feat_bit1: assert property (i_net_rd && i_net_addr == 16'h0008
    |=> !o_net_rdata[1]) else $error("reserved feature bit 1 set");
  a_sides_agree: assert property (i_net_rd && i_host_rd && i_host_addr == i_net_addr
    && !i_net_wr |=> o_host_rdata == o_net_rdata) else $error("sides read differently");
endmodule : sif_regs_checker
bind sif_regs sif_regs_checker i_sif_regs_checker (.i_sys_clk, .i_sys_rst, .i_net_rd,
  .i_net_wr, .i_net_addr, .i_net_wdata, .i_host_rd, .i_host_addr, .o_net_rdata,
  .o_host_rdata, .o_station_addr);

// ===== testbench/sif_master_model.sv
`timescale 1ns/10ps
// frame master and local host making byte accesses
module sif_master_model (
  input wire logic i_clk, // clock
  output logic o_net_rd, // network read strobe
  output logic o_net_wr, // network write strobe
  output logic o_host_rd, // host read strobe
  output logic o_host_wr, // host write strobe
  output logic [15:0] o_net_addr, // network byte address
  output logic [15:0] o_host_addr, // host byte address
  output logic [7:0] o_wdata // write byte, shared by both sides
);
  initial {o_net_rd, o_net_wr, o_host_rd, o_host_wr, o_net_addr, o_host_addr, o_wdata} = '0;
  // one access held for one edge; s is net rd, net wr, host rd, host wr
  task automatic acc(input logic [3:0] s, input logic [15:0] na, input logic [15:0] ha,
                     input logic [7:0] d);
    @(posedge i_clk);
    {o_net_rd, o_net_wr, o_host_rd, o_host_wr} <= s;
    o_net_addr <= na;
    o_host_addr <= ha;
    o_wdata <= d;
    @(posedge i_clk);
    {o_net_rd, o_net_wr, o_host_rd, o_host_wr} <= 4'h0;
    o_net_addr <= ~na;
    o_host_addr <= ~ha;
    o_wdata <= ~d;
  endtask : acc
endmodule : sif_master_model

// ===== testbench/sif_regs_tb_top.sv
`timescale 1ns/10ps
module sif_regs_tb_top;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic net_rd, net_wr, host_rd, host_wr;
  logic [3:0] st;
  logic [15:0] net_addr, host_addr, stad;
  logic [7:0] wd, net_q, host_q;
  int n_errors = 0, comparisons = 0, seed = 56216, sa = 0, a, h, d, e;
  int exp_q[$];
  // clock
  initial forever #5 i_sys_clk = ~i_sys_clk;
  sif_master_model i_sif_master_model (.i_clk(i_sys_clk), .o_net_rd(net_rd),
    .o_net_wr(net_wr), .o_host_rd(host_rd), .o_host_wr(host_wr), .o_net_addr(net_addr),
    .o_host_addr(host_addr), .o_wdata(wd));
  sif_regs i_sif_regs (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_net_rd(net_rd),
    .i_net_wr(net_wr), .i_net_addr(net_addr), .i_net_wdata(wd), .o_net_rdata(net_q),
    .i_host_rd(host_rd), .i_host_wr(host_wr), .i_host_addr(host_addr), .i_host_wdata(wd),
    .o_host_rdata(host_q), .o_station_addr(stad));
  // expected byte at each address
  function automatic int model(input int a);
    case (a)
      2: return 'h20;
      4: return 8;
      5: return 8;
      6: return 4;
      7: return 'h0F;
      8: return 'h84;
      16: return sa & 'hFF;
      17: return sa >> 8;
      default: return 0;
    endcase
  endfunction : model
  task automatic chk(input logic [15:0] got, input int exp);
    comparisons++;
    if (got !== exp[15:0]) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp[15:0]);
    end
  endtask : chk
  task automatic results;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  // cut a hang short
  initial begin
    #900000;
    n_errors++;
    results();
  end
  // reset, sweep both sides, random mixed traffic, then a second reset
  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    #1;
    chk(stad, 0);
    for (int i = 0; i < 300; i++) begin
      a = i < 20 ? i : $random(seed) & 'h1F;
      a = a > 19 ? a - 12 : a;
      h = i < 20 ? i : $random(seed) & 'h1F;
      h = h > 19 ? h - 12 : h;
      d = $random(seed) & 'hFF;
      st = i < 20 ? 4'hA : 4'($random(seed));
      exp_q.push_back(model(a));
      exp_q.push_back(model(h));
      i_sif_master_model.acc(st, a[15:0], h[15:0], d[7:0]);
      @(posedge i_sys_clk);
      #1;
      if (st[2] && a == 16) sa = (sa & 'hFF00) | d;
      if (st[2] && a == 17) sa = (sa & 'hFF) | (d << 8);
      chk(stad, sa);
      e = exp_q.pop_front();
      if (st[3]) chk(net_q, e);
      e = exp_q.pop_front();
      if (st[1]) chk(host_q, e);
    end
    // mid-run reset clears the station address
    @(posedge i_sys_clk);
    i_sys_rst <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    sa = 0;
    #1;
    chk(stad, 0);
    i_sif_master_model.acc(4'hA, 16'h0011, 16'h0010, 8'h00);
    @(posedge i_sys_clk);
    #1;
    chk(net_q, model(17));
    chk(host_q, model(16));
    results();
  end
endmodule : sif_regs_tb_top
